// ===== include/ambr_pkg.sv
// Function
// - Modulo correction on any working pointer
// - Bounds found by magnitude compare, not equality
// - Wrapped pointer written back only pre/post
// - Bit reverse only in X write generator
// - Only the modifier is bit reversed
// - Enable needs select not 15, bit, increment mode
// - Hold 15-bit pivot modifier
// - Word data, scaled pivot, address bit 0 clear
// - Byte or other modes give normal address
// - Pointer plus pivot, mode increment ignored
// - Bit reverse beats modulo in write generator
//
// Constants, register map and types of the address generator block.
// Assumes an APB master with 32-bit data and byte addresses.
package ambr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_BREV_CTRL = 8'h00;
  localparam logic [7:0] OFF_CIRC_CTRL = 8'h04;
  localparam logic [7:0] OFF_MOD_START = 8'h08;
  localparam logic [7:0] OFF_MOD_END = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // bit_reverse_control fields
  localparam int REV_EN_BIT = 15;
  localparam int PIVOT_W = 15;

  // circular_addressing_control fields
  localparam int MOD_SEL_LSB = 0;
  localparam int REV_SEL_LSB = 8;
  localparam int MOD_WR_EN_BIT = 14;
  localparam int MOD_RD_EN_BIT = 15;

  // Status fields
  localparam int ST_BITREV_BIT = 16;
  localparam int ST_WRAP_BIT = 17;

  // Reset values
  localparam logic [15:0] RST_BREV_CTRL = 16'h0000;
  localparam logic [15:0] RST_CIRC_CTRL = 16'h0F0F;
  localparam logic [15:0] RST_MOD_START = 16'h0000;
  localparam logic [15:0] RST_MOD_END = 16'hFFFF;

  // Pointer that can never be a bit-reversed pointer (stack)
  localparam logic [3:0] STACK_PTR_IDX = 4'hF;

  // Address steps in bytes
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  // Cycles from request to answer
  localparam int ANSWER_LATENCY = 1;

  typedef enum logic [2:0] {
    MODE_INDIRECT = 3'h0,
    MODE_POST_DEC = 3'h1,
    MODE_POST_INC = 3'h2,
    MODE_PRE_DEC = 3'h3,
    MODE_PRE_INC = 3'h4,
    MODE_OFFSET = 3'h5
  } ambr_mode_t;

endpackage : ambr_pkg

// ===== rtl/ambr_addr_gen.sv
// X data address generator: modulo correction and bit-reversed writes.
// Assumes requests come from the core on pclk; APB slave, zero wait.
`timescale 1ns/1ps
module ambr_addr_gen
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Address request from the core
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [3:0] req_ptr_idx,
  input wire logic [15:0] req_ptr,
  input wire logic [2:0] req_mode,
  input wire logic req_byte,
  input wire logic [15:0] req_offset,
  // Address answer
  output logic ea_valid,
  output logic [15:0] ea_addr,
  output logic ea_bitrev,
  output logic ea_wrapped,
  // Pointer write-back
  output logic wb_en,
  output logic [3:0] wb_idx,
  output logic [15:0] wb_value
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic mode_inc(input logic [2:0] m);
    mode_inc = (m == ambr_pkg::MODE_POST_INC) ||
               (m == ambr_pkg::MODE_PRE_INC);
  endfunction : mode_inc

  function automatic logic mode_dec(input logic [2:0] m);
    mode_dec = (m == ambr_pkg::MODE_POST_DEC) ||
               (m == ambr_pkg::MODE_PRE_DEC);
  endfunction : mode_dec

  function automatic logic mode_pre(input logic [2:0] m);
    mode_pre = (m == ambr_pkg::MODE_PRE_INC) ||
               (m == ambr_pkg::MODE_PRE_DEC);
  endfunction : mode_pre

  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0] brev_ctrl_r;
  logic [15:0] circ_ctrl_r;
  logic [15:0] mod_start_r;
  logic [15:0] mod_end_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  logic apb_access;
  logic addr_ok;
  logic rev_en;
  logic [ambr_pkg::PIVOT_W-1:0] pivot_modifier;
  logic [3:0] rev_ptr_sel;
  logic [3:0] mod_ptr_sel;
  logic mod_rd_en;
  logic mod_wr_en;

  assign apb_access = psel && penable;
  assign addr_ok = reg_hit(paddr, ambr_pkg::OFF_BREV_CTRL) ||
                   reg_hit(paddr, ambr_pkg::OFF_CIRC_CTRL) ||
                   reg_hit(paddr, ambr_pkg::OFF_MOD_START) ||
                   reg_hit(paddr, ambr_pkg::OFF_MOD_END) ||
                   reg_hit(paddr, ambr_pkg::OFF_STATUS);

  assign rev_en = brev_ctrl_r[ambr_pkg::REV_EN_BIT];
  assign pivot_modifier = brev_ctrl_r[ambr_pkg::PIVOT_W-1:0];
  assign rev_ptr_sel = circ_ctrl_r[ambr_pkg::REV_SEL_LSB +: 4];
  assign mod_ptr_sel = circ_ctrl_r[ambr_pkg::MOD_SEL_LSB +: 4];
  assign mod_rd_en = circ_ctrl_r[ambr_pkg::MOD_RD_EN_BIT];
  assign mod_wr_en = circ_ctrl_r[ambr_pkg::MOD_WR_EN_BIT];

  // Zero wait: every access completes in its first access cycle
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brev_ctrl_r <= ambr_pkg::RST_BREV_CTRL;
      circ_ctrl_r <= ambr_pkg::RST_CIRC_CTRL;
      mod_start_r <= ambr_pkg::RST_MOD_START;
      mod_end_r <= ambr_pkg::RST_MOD_END;
    end
    else if (apb_access && pwrite)
    begin
      if (reg_hit(paddr, ambr_pkg::OFF_BREV_CTRL))
        brev_ctrl_r <= pwdata[15:0];
      if (reg_hit(paddr, ambr_pkg::OFF_CIRC_CTRL))
        circ_ctrl_r <= pwdata[15:0];
      if (reg_hit(paddr, ambr_pkg::OFF_MOD_START))
        mod_start_r <= pwdata[15:0];
      if (reg_hit(paddr, ambr_pkg::OFF_MOD_END))
        mod_end_r <= pwdata[15:0];
    end
  end

  // Read data and error are registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr_r <= !addr_ok;
      prdata_r <= 32'h00000000;
      if (!pwrite)
      begin
        if (reg_hit(paddr, ambr_pkg::OFF_BREV_CTRL))
          prdata_r <= {16'h0000, brev_ctrl_r};
        if (reg_hit(paddr, ambr_pkg::OFF_CIRC_CTRL))
          prdata_r <= {16'h0000, circ_ctrl_r};
        if (reg_hit(paddr, ambr_pkg::OFF_MOD_START))
          prdata_r <= {16'h0000, mod_start_r};
        if (reg_hit(paddr, ambr_pkg::OFF_MOD_END))
          prdata_r <= {16'h0000, mod_end_r};
        if (reg_hit(paddr, ambr_pkg::OFF_STATUS))
          prdata_r <= {14'h0000, ea_wrapped, ea_bitrev, ea_addr};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit-reversed path

  logic br_active;
  logic [ambr_pkg::PIVOT_W-1:0] br_field;
  logic [15:0] br_sum;

  // Write generator only, stack pointer excluded, word increment modes
  assign br_active = req_write && rev_en &&
                     (rev_ptr_sel != ambr_pkg::STACK_PTR_IDX) &&
                     (req_ptr_idx == rev_ptr_sel) &&
                     mode_inc(req_mode) &&
                     !req_byte;

  ambr_revcarry u_revcarry
  (
    .base (req_ptr[15:1]),
    .pivot (pivot_modifier),
    .sum (br_field)
  );

  // Pivot scaled to bytes by sitting above bit 0
  assign br_sum = {br_field, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Normal path with modulo correction

  logic [15:0] step;
  logic [15:0] raw_next;
  logic [15:0] raw_ea;
  logic [15:0] mod_len;
  logic mod_sel;
  logic hi_out;
  logic lo_out;
  logic wrap_ea;
  logic wrap_next;
  logic [15:0] fix_next;
  logic [15:0] fix_ea;

  assign step = req_byte ? ambr_pkg::STEP_BYTE : ambr_pkg::STEP_WORD;
  assign mod_len = 16'(mod_end_r - mod_start_r + 16'h0001);

  always_comb
  begin
    raw_next = req_ptr;
    if (mode_inc(req_mode))
      raw_next = 16'(req_ptr + step);
    else if (mode_dec(req_mode))
      raw_next = 16'(req_ptr - step);
  end

  always_comb
  begin
    raw_ea = req_ptr;
    if (mode_pre(req_mode))
      raw_ea = raw_next;
    else if (req_mode == ambr_pkg::MODE_OFFSET)
      raw_ea = 16'(req_ptr + req_offset);
  end

  // Any pointer may be the circular one; bit reverse masks it on writes
  assign mod_sel = (req_ptr_idx == mod_ptr_sel) &&
                   (req_write ? (mod_wr_en && !br_active)
                              : mod_rd_en);

  // Magnitude compares so oversized steps still wrap
  assign hi_out = (req_mode == ambr_pkg::MODE_OFFSET) ?
                  (raw_ea > mod_end_r) : (raw_next > mod_end_r);
  assign lo_out = (req_mode == ambr_pkg::MODE_OFFSET) ?
                  (raw_ea < mod_start_r) : (raw_next < mod_start_r);

  always_comb
  begin
    fix_next = raw_next;
    wrap_next = 1'b0;
    if (mod_sel && mode_inc(req_mode) && hi_out)
    begin
      fix_next = 16'(raw_next - mod_len);
      wrap_next = 1'b1;
    end
    else if (mod_sel && mode_dec(req_mode) && lo_out)
    begin
      fix_next = 16'(raw_next + mod_len);
      wrap_next = 1'b1;
    end
  end

  always_comb
  begin
    fix_ea = raw_ea;
    wrap_ea = 1'b0;
    if (mode_pre(req_mode))
    begin
      fix_ea = fix_next;
      wrap_ea = wrap_next;
    end
    else if (mod_sel && (req_mode == ambr_pkg::MODE_OFFSET))
    begin
      // Access uses the corrected address, pointer stays put
      if (hi_out)
      begin
        fix_ea = 16'(raw_ea - mod_len);
        wrap_ea = 1'b1;
      end
      else if (lo_out)
      begin
        fix_ea = 16'(raw_ea + mod_len);
        wrap_ea = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer registers, one cycle after the request

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ea_valid <= 1'b0;
      ea_addr <= 16'h0000;
      ea_bitrev <= 1'b0;
      ea_wrapped <= 1'b0;
    end
    else
    begin
      ea_valid <= req_valid;
      if (req_valid && br_active)
      begin
        // Pointer and result stay in normal order, bit 0 forced low
        ea_addr <= mode_pre(req_mode) ? br_sum
                                      : {req_ptr[15:1], 1'b0};
        ea_bitrev <= 1'b1;
        ea_wrapped <= 1'b0;
      end
      else if (req_valid)
      begin
        ea_addr <= fix_ea;
        ea_bitrev <= 1'b0;
        ea_wrapped <= wrap_ea || (wrap_next && !mode_pre(req_mode));
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wb_en <= 1'b0;
      wb_idx <= 4'h0;
      wb_value <= 16'h0000;
    end
    else
    begin
      // Only pre and post modify modes update the pointer
      wb_en <= req_valid && (mode_inc(req_mode) || mode_dec(req_mode));
      if (req_valid)
      begin
        wb_idx <= req_ptr_idx;
        wb_value <= br_active ? br_sum : fix_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_offset_no_wb;
    @(posedge pclk) disable iff (!presetn)
    req_valid && (req_mode == ambr_pkg::MODE_OFFSET) |=> !wb_en;
  endproperty
  a_offset_no_wb: assert property (p_offset_no_wb)
    else $error("offset mode wrote the pointer back");

  property p_read_no_bitrev;
    @(posedge pclk) disable iff (!presetn)
    req_valid && !req_write |=> !ea_bitrev;
  endproperty
  a_read_no_bitrev: assert property (p_read_no_bitrev)
    else $error("bit reverse used on a read");

  property p_stack_excluded;
    @(posedge pclk) disable iff (!presetn)
    req_valid && (req_ptr_idx == ambr_pkg::STACK_PTR_IDX) |=> !ea_bitrev;
  endproperty
  a_stack_excluded: assert property (p_stack_excluded)
    else $error("bit reverse used on the stack pointer");

  property p_byte_normal;
    @(posedge pclk) disable iff (!presetn)
    req_valid && (req_byte || !mode_inc(req_mode)) |=> !ea_bitrev;
  endproperty
  a_byte_normal: assert property (p_byte_normal)
    else $error("bit reverse on byte or wrong mode");

  property p_bitrev_lsb;
    @(posedge pclk) disable iff (!presetn)
    ea_valid && ea_bitrev |-> !ea_addr[0] && (!wb_en || !wb_value[0]);
  endproperty
  a_bitrev_lsb: assert property (p_bitrev_lsb)
    else $error("bit reversed address with bit 0 set");

  property p_bitrev_update;
    @(posedge pclk) disable iff (!presetn)
    req_valid && br_active |=> ea_bitrev && wb_en &&
      (wb_value == $past(br_sum));
  endproperty
  a_bitrev_update: assert property (p_bitrev_update)
    else $error("bit reversed pointer not pointer plus pivot");

  property p_bitrev_no_wrap;
    @(posedge pclk) disable iff (!presetn)
    ea_valid && ea_bitrev |-> !ea_wrapped;
  endproperty
  a_bitrev_no_wrap: assert property (p_bitrev_no_wrap)
    else $error("modulo applied under bit reverse");

  property p_wrap_in_range;
    @(posedge pclk) disable iff (!presetn)
    ea_valid && ea_wrapped && wb_en |->
      (wb_value >= mod_start_r) && (wb_value <= mod_end_r);
  endproperty
  a_wrap_in_range: assert property (p_wrap_in_range)
    else $error("wrapped pointer outside the buffer");

  property p_answer_latency;
    @(posedge pclk) disable iff (!presetn)
    req_valid |=> ea_valid ##1 (ea_valid == $past(req_valid));
  endproperty
  a_answer_latency: assert property (p_answer_latency)
    else $error("answer not one cycle after request");

endmodule : ambr_addr_gen

// ===== rtl/ambr_revcarry.sv
// Reverse-carry adder for the 15-bit bit-reversed pointer field.
// Assumes operands already sit in normal bit order.
`timescale 1ns/1ps
module ambr_revcarry
(
  // Operands
  input wire logic [ambr_pkg::PIVOT_W-1:0] base,
  input wire logic [ambr_pkg::PIVOT_W-1:0] pivot,
  // Result
  output logic [ambr_pkg::PIVOT_W-1:0] sum
);

  logic [ambr_pkg::PIVOT_W-1:0] base_rev;
  logic [ambr_pkg::PIVOT_W-1:0] pivot_rev;
  logic [ambr_pkg::PIVOT_W-1:0] sum_rev;

  ////////////////////////////////////////////////////////////////////////////
  // Mirror in, add, mirror out: carries run from msb toward lsb
  genvar i;
  generate
    for (i = 0; i < ambr_pkg::PIVOT_W; i = i + 1)
    begin : g_mirror
      assign base_rev[i] = base[ambr_pkg::PIVOT_W-1-i];
      assign pivot_rev[i] = pivot[ambr_pkg::PIVOT_W-1-i];
      assign sum[i] = sum_rev[ambr_pkg::PIVOT_W-1-i];
    end
  endgenerate

  // Carry out of the field is dropped
  assign sum_rev = base_rev + pivot_rev;

endmodule : ambr_revcarry

// ===== test/ambr_core_model.sv
// Core-side model: issues address requests as the execution path does.
// Assumes one pclk domain; the answer comes one cycle later.
`timescale 1ns/1ps
module ambr_core_model
(
  // Clock
  input wire logic pclk,
  // Request
  output logic req_valid,
  output logic req_write,
  output logic [3:0] req_ptr_idx,
  output logic [15:0] req_ptr,
  output logic [2:0] req_mode,
  output logic req_byte,
  output logic [15:0] req_offset
);
  initial
  begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_ptr_idx = 4'h0;
    req_ptr = 16'h0000;
    req_mode = 3'h0;
    req_byte = 1'b0;
    req_offset = 16'h0000;
  end

  task automatic issue(input logic wr, input logic [3:0] idx,
    input logic [15:0] ptr, input logic [2:0] md, input logic bt,
    input logic [15:0] off);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_ptr_idx <= idx;
    req_ptr <= ptr;
    req_mode <= md;
    req_byte <= bt;
    req_offset <= off;
    @(posedge pclk);
    // Idle lines except req_mode invert so a stale request cannot pass
    req_valid <= 1'b0;
    req_write <= ~wr;
    req_ptr_idx <= ~idx;
    req_ptr <= ~ptr;
    req_byte <= ~bt;
    req_offset <= ~off;
    @(negedge pclk);
  endtask : issue
endmodule : ambr_core_model

// ===== test/tb.sv
// Testbench of the address generator: APB set-up, core requests.
// Assumes zero-wait APB slave and one-cycle request answer.
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  logic req_valid, req_write, req_byte;
  logic [3:0] req_ptr_idx, wb_idx;
  logic [15:0] req_ptr, req_offset, ea_addr, wb_value;
  logic [2:0] req_mode;
  logic ea_valid, ea_bitrev, ea_wrapped, wb_en;
  int n_errors = 0;
  int total_checks = 0;

  ambr_addr_gen ambr_addr_gen_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .req_valid,
    .req_write, .req_ptr_idx, .req_ptr, .req_mode, .req_byte,
    .req_offset, .ea_valid, .ea_addr, .ea_bitrev, .ea_wrapped, .wb_en,
    .wb_idx, .wb_value);
  ambr_core_model ambr_core_model_i (.pclk, .req_valid, .req_write,
    .req_ptr_idx, .req_ptr, .req_mode, .req_byte, .req_offset);

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic final_report();
    $display("Checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait ends once pready is high; the watchdog ends a wait that hangs
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd

  // Request, then compare the answer one cycle later
  task automatic rq(input logic w, input logic [3:0] i,
    input logic [15:0] p, input logic [2:0] m, input logic bt,
    input logic [15:0] o, input logic [15:0] ea, input logic we,
    input logic [15:0] wv, input logic br, input logic wp);
    ambr_core_model_i.issue(w, i, p, m, bt, o);
    chk({31'h0, ea_valid}, 32'h0000_0001);
    chk({16'h0, ea_addr}, {16'h0, ea});
    chk({31'h0, wb_en}, {31'h0, we});
    chk({30'h0, ea_bitrev, ea_wrapped}, {30'h0, br, wp});
    if (we)
      chk({12'h0, wb_idx, wb_value}, {12'h0, i, wv});
  endtask : rq

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(ambr_pkg::OFF_BREV_CTRL, {16'h0, ambr_pkg::RST_BREV_CTRL}, 1'b0);
    rd(ambr_pkg::OFF_CIRC_CTRL, {16'h0, ambr_pkg::RST_CIRC_CTRL}, 1'b0);
    rd(ambr_pkg::OFF_MOD_END, {16'h0, ambr_pkg::RST_MOD_END}, 1'b0);
    rd(8'h14, 32'h0000_0000, 1'b1);
    wr(ambr_pkg::OFF_BREV_CTRL, 32'hFFFF_7123);
    rd(ambr_pkg::OFF_BREV_CTRL, 32'h0000_7123, 1'b0);
    $display("regs test done");
  endtask : t_regs

  task automatic t_mod();
    wr(ambr_pkg::OFF_CIRC_CTRL, 32'h0000_C00C);
    wr(ambr_pkg::OFF_MOD_START, 32'h0000_1000);
    wr(ambr_pkg::OFF_MOD_END, 32'h0000_100F);
    rq(1'b0, 4'hC, 16'h100E, ambr_pkg::MODE_POST_INC, 1'b0, 16'h0,
      16'h100E, 1'b1, 16'h1000, 1'b0, 1'b1);
    rq(1'b0, 4'hC, 16'h100F, ambr_pkg::MODE_PRE_INC, 1'b0, 16'h0,
      16'h1001, 1'b1, 16'h1001, 1'b0, 1'b1);
    rq(1'b0, 4'hC, 16'h1000, ambr_pkg::MODE_PRE_DEC, 1'b0, 16'h0,
      16'h100E, 1'b1, 16'h100E, 1'b0, 1'b1);
    rq(1'b0, 4'hC, 16'h1008, ambr_pkg::MODE_OFFSET, 1'b0, 16'h000A,
      16'h1002, 1'b0, 16'h0, 1'b0, 1'b1);
    rq(1'b0, 4'h6, 16'h100E, ambr_pkg::MODE_POST_INC, 1'b0, 16'h0,
      16'h100E, 1'b1, 16'h1010, 1'b0, 1'b0);
    rq(1'b0, 4'hC, 16'h1006, ambr_pkg::MODE_INDIRECT, 1'b0, 16'h0,
      16'h1006, 1'b0, 16'h0, 1'b0, 1'b0);
    $display("modulo test done");
  endtask : t_mod

  task automatic t_rev();
    logic [15:0] s [4];
    logic [15:0] p;
    s = '{16'h1008, 16'h1004, 16'h100C, 16'h1002};
    wr(ambr_pkg::OFF_CIRC_CTRL, 32'h0000_C303);
    wr(ambr_pkg::OFF_MOD_END, 32'h0000_1007);
    wr(ambr_pkg::OFF_BREV_CTRL, 32'h0000_8004);
    @(posedge pclk); // idle after control write
    p = 16'h1000; // buffer start aligned
    for (int n = 0; n < 4; n++)
    begin
      rq(1'b1, 4'h3, p, ambr_pkg::MODE_PRE_INC, 1'b0, 16'h0,
        s[n], 1'b1, s[n], 1'b1, 1'b0);
      p = s[n];
    end
    rq(1'b1, 4'h3, 16'h1003, ambr_pkg::MODE_POST_INC, 1'b0, 16'h0,
      16'h1002, 1'b1, 16'h100A, 1'b1, 1'b0);
    rd(ambr_pkg::OFF_STATUS, 32'h0001_1002, 1'b0);
    rq(1'b0, 4'h3, 16'h1006, ambr_pkg::MODE_POST_INC, 1'b0, 16'h0,
      16'h1006, 1'b1, 16'h1000, 1'b0, 1'b1);
    rd(ambr_pkg::OFF_STATUS, 32'h0002_1006, 1'b0);
    rq(1'b1, 4'h3, 16'h1002, ambr_pkg::MODE_POST_INC, 1'b1, 16'h0,
      16'h1002, 1'b1, 16'h1003, 1'b0, 1'b0);
    rq(1'b1, 4'h3, 16'h1004, ambr_pkg::MODE_POST_DEC, 1'b0, 16'h0,
      16'h1004, 1'b1, 16'h1002, 1'b0, 1'b0);
    wr(ambr_pkg::OFF_CIRC_CTRL, 32'h0000_0F00);
    rq(1'b1, 4'hF, 16'h2000, ambr_pkg::MODE_POST_INC, 1'b0, 16'h0,
      16'h2000, 1'b1, 16'h2002, 1'b0, 1'b0);
    wr(ambr_pkg::OFF_CIRC_CTRL, 32'h0000_0300);
    wr(ambr_pkg::OFF_BREV_CTRL, 32'h0000_0004);
    rq(1'b1, 4'h3, 16'h1000, ambr_pkg::MODE_POST_INC, 1'b0, 16'h0,
      16'h1000, 1'b1, 16'h1002, 1'b0, 1'b0);
    $display("bit reverse test done");
  endtask : t_rev

  // Reset in mid-run: outputs and registers back to reset values
  task automatic t_rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({ea_addr, wb_value}, 32'h0000_0000);
    chk({26'h0, wb_idx, ea_valid, wb_en}, 32'h0000_0000);
    chk(prdata, 32'h0000_0000);
    presetn <= 1'b1;
    rd(ambr_pkg::OFF_BREV_CTRL, {16'h0, ambr_pkg::RST_BREV_CTRL}, 1'b0);
    rd(ambr_pkg::OFF_CIRC_CTRL, {16'h0, ambr_pkg::RST_CIRC_CTRL}, 1'b0);
    rd(ambr_pkg::OFF_MOD_END, {16'h0, ambr_pkg::RST_MOD_END}, 1'b0);
    rd(ambr_pkg::OFF_STATUS, 32'h0000_0000, 1'b0);
    $display("reset test done");
  endtask : t_rst

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_mod();
    t_rev();
    t_rst();
    final_report();
  end

  // Tests need about a hundred cycles; far beyond means a hang
  initial
  begin
    #(4000 * 50);
    n_errors++;
    $display("Error at %0t: timeout", $time);
    final_report();
  end
endmodule : tb
